// ### rtl/acs_pkg.sv
// constants shared by the conversion sequencer files
package acs_pkg;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned NUM_SLOT = 8;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CFG = 12'h004;
    localparam logic [11:0] OFS_PRESC = 12'h008;
    localparam logic [11:0] OFS_CMP = 12'h00c;
    localparam logic [11:0] OFS_SWEEP = 12'h010;
    localparam logic [11:0] OFS_FLAGS = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h018;
    localparam logic [11:0] OFS_CH_BASE = 12'h020;
    localparam logic [11:0] OFS_CH_END = 12'h060;
    // word index inside a channel block
    localparam logic [1:0] CH_SUB_CFG = 2'h0;
    localparam logic [1:0] CH_SUB_INSEL = 2'h1;
    localparam logic [1:0] CH_SUB_RESULT = 2'h2;
    // field positions
    localparam int unsigned CTRL_ENABLE = 0;
    localparam int unsigned CTRL_START_LSB = 2;
    localparam int unsigned CTRL_DMASEL_LSB = 6;
    localparam int unsigned CFG_RES_LSB = 1;
    localparam int unsigned CFG_FREERUN = 3;
    localparam int unsigned CFG_SIGNED = 4;
    localparam int unsigned CFG_IMPMODE = 7;
    localparam int unsigned CHCFG_GAIN = 0;
    localparam int unsigned CHCFG_MODE_LSB = 2;
    localparam int unsigned CHCFG_IRQEN = 4;
    localparam int unsigned INSEL_SCAN_LSB = 4;
    // result formats
    typedef enum logic [1:0] {
        ACS_RES_12R = 2'h0,
        ACS_RES_RSVD = 2'h1,
        ACS_RES_8R = 2'h2,
        ACS_RES_12L = 2'h3
    } acs_res_t;
    // interrupt and event conditions
    typedef enum logic [1:0] {
        ACS_IRQ_DONE = 2'h0,
        ACS_IRQ_ABOVE = 2'h1,
        ACS_IRQ_BELOW = 2'h2,
        ACS_IRQ_RSVD = 2'h3
    } acs_mode_t;
    // converter cycles
    localparam logic [3:0] RES_BITS_8 = 4'h8;
    localparam logic [3:0] RES_BITS_12 = 4'hc;
    localparam logic [3:0] MSB_CYCLES = 4'h1;
    localparam logic [3:0] GAIN_CYCLES = 4'h1;
    localparam logic [9:0] PRESC_MIN_DIV = 10'h004;
    localparam logic [11:0] MSB_MASK = 12'h800;
    localparam logic [11:0] PAIR_MASK = 12'h003;
endpackage : acs_pkg

// ### rtl/acs_prescaler.sv
// converter clock prescaler driven from the peripheral clock
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] div_sel,
    output logic conv_tick,
    output logic conv_clk
);
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic [9:0] div_last;

    // divide by 4, 8, ... 512
    assign div_last = (PRESC_MIN_DIV << div_sel) - 10'h001;
    assign cnt_next = (cnt_reg >= div_last) ? 10'h000 : cnt_reg + 10'h001;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 10'h000;
            conv_tick <= 1'b0;
            conv_clk <= 1'b0;
        end
        else if (!run)
        begin
            // stopped converter restarts from a full period
            cnt_reg <= 10'h000;
            conv_tick <= 1'b0;
            conv_clk <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            conv_tick <= (cnt_reg >= div_last);
            conv_clk <= (cnt_next < (div_last >> 1));
        end
    end
endmodule : acs_prescaler
`default_nettype wire

// ### rtl/acs_top.sv
// pipelined four-channel conversion sequencer with apb registers
//
// Overview of operation
// - a channel may flag on completion or when its result is above or below threshold
// - one 12-bit threshold register serves all four channels
// - conversions start from a software start bit or an event line
// - simultaneous requests begin in ascending channel order, lowest first
// - channel 0 scans consecutive inputs, stepping selection per conversion
// - converter clock comes from the peripheral clock through a prescaler
// - a new sample can be taken on every converter clock cycle
// - latency is one plus half the resolution, plus one with gain
// - msb first, then two bits per cycle for three or five cycles
// - last latency cycle assembles result, then sets completion flag
// - requests arrive a peripheral cycle before the converter cycle used
// - without gain the input is sampled in the first conversion cycle
// - gain adds one cycle before the converter sample
// - next channel starts the converter cycle after the previous start
// - after a gain channel the next sample waits one extra cycle
// - free run sweeps selected channels repeatedly, eight in flight
// - low-impedance gain mode discharges the capacitor after each gain sample
// - a fresh result raises a dma request for one channel or a group
// - each channel has its own interrupt and event on done or compare
// - lowest channel is granted first within one converter period
// - a start bit clears itself once its conversion has begun
// - signed 12-bit right format copies bit 11 into bits 12 to 15
`timescale 1ns/1ps
`default_nettype none
module acs_top
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] event_in,
    input wire logic [11:0] adc_raw,
    output logic conv_clk,
    output logic adc_enable,
    output logic sample_strobe,
    output logic [3:0] sample_input,
    output logic gain_sample,
    output logic cap_discharge,
    output logic [3:0] irq,
    output logic [3:0] event_out,
    output logic [3:0] dma_req,
    output logic dma_group_req
);
    import acs_pkg::*;

    function automatic logic [1:0] lowest_idx(input logic [3:0] v);
        lowest_idx = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
    endfunction : lowest_idx

    function automatic logic [3:0] latency(input acs_res_t r, input logic g);
        logic [3:0] bits;
        bits = (r == ACS_RES_8R) ? RES_BITS_8 : RES_BITS_12;
        latency = MSB_CYCLES + (bits >> 1) + (g ? GAIN_CYCLES : 4'h0);
    endfunction : latency

    function automatic logic [15:0] format(input logic [11:0] v,
                                           input acs_res_t r,
                                           input logic sgn);
        case (r)
            ACS_RES_8R: format = {{8{sgn & v[11]}}, v[11:4]};
            ACS_RES_12L: format = {v, 4'h0};
            default: format = {{4{sgn & v[11]}}, v};
        endcase
    endfunction : format

    logic enable_reg;
    logic [3:0] start_reg;
    logic [1:0] dmasel_reg;
    logic impmode_reg;
    logic signed_reg;
    logic freerun_reg;
    acs_res_t res_reg;
    logic [2:0] presc_reg;
    logic [11:0] cmp_reg;
    logic [3:0] sweep_reg;
    logic [3:0] flag_reg;
    logic [3:0] gain_reg;
    logic [3:0] irqen_reg;
    acs_mode_t mode_reg [NUM_CH];
    logic [3:0] insel_reg [NUM_CH];
    logic [2:0] scan_cnt_reg;
    logic [2:0] scan_ofs_reg;
    logic scan_pend_reg;
    logic [15:0] result_reg [NUM_CH];
    logic [3:0] evt_pend_reg;
    logic [3:0] fr_pend_reg;
    logic hold_reg;
    logic [NUM_SLOT-1:0] slot_v_reg;
    logic [1:0] slot_ch_reg [NUM_SLOT];
    logic [3:0] slot_age_reg [NUM_SLOT];
    logic [NUM_SLOT-1:0] slot_gain_reg;
    logic [11:0] slot_raw_reg [NUM_SLOT];
    logic [11:0] slot_acc_reg [NUM_SLOT];

    logic conv_tick;
    logic wr_en;
    logic [1:0] ch_idx;
    logic [1:0] ch_sub;
    logic in_ch;
    logic [3:0] pend;
    logic [1:0] grant;
    logic start_go;
    logic free_any;
    logic [2:0] free_idx;
    logic [NUM_SLOT-1:0] fin;
    logic [3:0] done;
    logic [11:0] done_val [NUM_CH];
    logic [3:0] hit;
    logic [3:0] grp_mask;

    assign wr_en = psel & penable & pwrite & pready;
    assign in_ch = (paddr >= OFS_CH_BASE) && (paddr < OFS_CH_END);
    assign ch_idx = 2'((paddr - OFS_CH_BASE) >> 4);
    assign ch_sub = paddr[3:2];

    acs_prescaler u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .run(enable_reg),
        .div_sel(presc_reg),
        .conv_tick(conv_tick),
        .conv_clk(conv_clk)
    );

    // software, event, scan and sweep requests merge
    assign pend = start_reg | evt_pend_reg | fr_pend_reg
                  | {3'h0, scan_pend_reg};

    always_comb
    begin
        free_any = 1'b0;
        free_idx = 3'h0;
        for (int i = NUM_SLOT - 1; i >= 0; i--)
        begin
            if (!slot_v_reg[i])
            begin
                free_any = 1'b1;
                free_idx = 3'(i);
            end
        end
    end

    assign grant = lowest_idx(pend);
    // one start per converter cycle; hold after gain start
    assign start_go = conv_tick & enable_reg & (|pend) & free_any & !hold_reg;

    // completion when the slot reaches its last latency cycle
    always_comb
    begin
        done = 4'h0;
        for (int c = 0; c < NUM_CH; c++)
            done_val[c] = 12'h000;
        for (int i = 0; i < NUM_SLOT; i++)
        begin
            fin[i] = conv_tick & slot_v_reg[i]
                     & (slot_age_reg[i] + 4'h1
                        == latency(res_reg, slot_gain_reg[i]) - 4'h1);
            if (fin[i])
            begin
                done[slot_ch_reg[i]] = 1'b1;
                // last cycle resolves the remaining bits
                done_val[slot_ch_reg[i]] = slot_acc_reg[i] | slot_raw_reg[i];
            end
        end
    end

    // above or below the shared threshold, sign aware
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            logic gt;
            logic lt;
            gt = signed_reg ? ($signed(done_val[c]) > $signed(cmp_reg))
                            : (done_val[c] > cmp_reg);
            lt = signed_reg ? ($signed(done_val[c]) < $signed(cmp_reg))
                            : (done_val[c] < cmp_reg);
            case (mode_reg[c])
                ACS_IRQ_DONE: hit[c] = done[c];
                ACS_IRQ_ABOVE: hit[c] = done[c] & gt;
                ACS_IRQ_BELOW: hit[c] = done[c] & lt;
                default: hit[c] = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        case (dmasel_reg)
            2'h1: grp_mask = 4'h3;
            2'h2: grp_mask = 4'h7;
            2'h3: grp_mask = 4'hf;
            default: grp_mask = 4'h0;
        endcase
    end

    // apb slave: data latched in setup, answered in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable)
            begin
                if (in_ch)
                begin
                    case (ch_sub)
                        CH_SUB_CFG: prdata <= {27'h0, irqen_reg[ch_idx],
                            mode_reg[ch_idx], 1'b0, gain_reg[ch_idx]};
                        CH_SUB_INSEL: prdata <= {25'h0,
                            (ch_idx == 2'd0) ? scan_cnt_reg : 3'h0,
                            insel_reg[ch_idx]};
                        CH_SUB_RESULT: prdata <= {16'h0, result_reg[ch_idx]};
                        default: pslverr <= 1'b1;
                    endcase
                end
                else
                begin
                    case (paddr)
                        OFS_CTRL: prdata <= {24'h0, dmasel_reg, start_reg,
                                             1'b0, enable_reg};
                        OFS_CFG: prdata <= {24'h0, impmode_reg, 2'h0,
                                 signed_reg, freerun_reg, res_reg, 1'b0};
                        OFS_PRESC: prdata <= {29'h0, presc_reg};
                        OFS_CMP: prdata <= {20'h0, cmp_reg};
                        OFS_SWEEP: prdata <= {28'h0, sweep_reg};
                        OFS_FLAGS: prdata <= {28'h0, flag_reg};
                        OFS_STATUS: prdata <= {20'h0, pend, slot_v_reg};
                        default: pslverr <= 1'b1;
                    endcase
                end
            end
        end
    end

    // configuration registers written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_reg <= 1'b0;
            dmasel_reg <= 2'h0;
            impmode_reg <= 1'b0;
            signed_reg <= 1'b0;
            freerun_reg <= 1'b0;
            res_reg <= ACS_RES_12R;
            presc_reg <= 3'h0;
            cmp_reg <= 12'h000;
            sweep_reg <= 4'h0;
            gain_reg <= 4'h0;
            irqen_reg <= 4'h0;
            scan_cnt_reg <= 3'h0;
            for (int c = 0; c < NUM_CH; c++)
            begin
                mode_reg[c] <= ACS_IRQ_DONE;
                insel_reg[c] <= 4'h0;
            end
        end
        else if (wr_en && in_ch)
        begin
            if (ch_sub == CH_SUB_CFG)
            begin
                gain_reg[ch_idx] <= pwdata[CHCFG_GAIN];
                mode_reg[ch_idx] <= acs_mode_t'(pwdata[CHCFG_MODE_LSB +: 2]);
                irqen_reg[ch_idx] <= pwdata[CHCFG_IRQEN];
            end
            if (ch_sub == CH_SUB_INSEL)
            begin
                insel_reg[ch_idx] <= pwdata[3:0];
                if (ch_idx == 2'd0)
                    scan_cnt_reg <= pwdata[INSEL_SCAN_LSB +: 3];
            end
        end
        else if (wr_en)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    enable_reg <= pwdata[CTRL_ENABLE];
                    dmasel_reg <= pwdata[CTRL_DMASEL_LSB +: 2];
                end
                OFS_CFG:
                begin
                    impmode_reg <= pwdata[CFG_IMPMODE];
                    signed_reg <= pwdata[CFG_SIGNED];
                    freerun_reg <= pwdata[CFG_FREERUN];
                    res_reg <= acs_res_t'(pwdata[CFG_RES_LSB +: 2]);
                end
                OFS_PRESC: presc_reg <= pwdata[2:0];
                OFS_CMP: cmp_reg <= pwdata[11:0];
                OFS_SWEEP: sweep_reg <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // start requests; a new request in the start cycle is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_reg <= 4'h0;
            evt_pend_reg <= 4'h0;
            fr_pend_reg <= 4'h0;
        end
        else
        begin
            // start bit cleared once the conversion begins
            start_reg <= (start_reg & ~(start_go ? 4'(1) << grant : 4'h0))
                | ((wr_en && !in_ch && paddr == OFS_CTRL)
                   ? pwdata[CTRL_START_LSB +: 4] : 4'h0);
            // registered here, so used from the next converter cycle
            evt_pend_reg <= (evt_pend_reg
                             & ~(start_go ? 4'(1) << grant : 4'h0))
                            | event_in;
            // reload the sweep once every selected channel started
            if (!freerun_reg)
                fr_pend_reg <= 4'h0;
            else if (start_go)
                fr_pend_reg <= ((fr_pend_reg & ~(4'(1) << grant)) == 4'h0)
                               ? sweep_reg : fr_pend_reg & ~(4'(1) << grant);
            else if (fr_pend_reg == 4'h0)
                fr_pend_reg <= sweep_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_ofs_reg <= 3'h0;
            scan_pend_reg <= 1'b0;
        end
        else if (start_go && grant == 2'd0)
        begin
            if (scan_ofs_reg < scan_cnt_reg)
            begin
                scan_ofs_reg <= scan_ofs_reg + 3'h1;
                scan_pend_reg <= 1'b1;
            end
            else
            begin
                scan_ofs_reg <= 3'h0;
                scan_pend_reg <= 1'b0;
            end
        end
    end

    // conversion slots, each with its own age counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_v_reg <= '0;
            slot_gain_reg <= '0;
            hold_reg <= 1'b0;
            for (int i = 0; i < NUM_SLOT; i++)
            begin
                slot_ch_reg[i] <= 2'h0;
                slot_age_reg[i] <= 4'h0;
                slot_raw_reg[i] <= 12'h000;
                slot_acc_reg[i] <= 12'h000;
            end
        end
        else if (!enable_reg)
        begin
            slot_v_reg <= '0;
            hold_reg <= 1'b0;
        end
        else if (conv_tick)
        begin
            // a gain start blocks the following converter cycle
            hold_reg <= start_go & gain_reg[grant];
            for (int i = 0; i < NUM_SLOT; i++)
            begin
                if (fin[i])
                    slot_v_reg[i] <= 1'b0;
                else if (slot_v_reg[i])
                begin
                    logic [3:0] k;
                    k = slot_age_reg[i] + 4'h1
                        - (slot_gain_reg[i] ? GAIN_CYCLES : 4'h0);
                    slot_age_reg[i] <= slot_age_reg[i] + 4'h1;
                    // gain slot reaches the converter sample one late
                    if (k == 4'h0)
                    begin
                        slot_raw_reg[i] <= adc_raw;
                        slot_acc_reg[i] <= adc_raw & MSB_MASK;
                    end
                    // two further bits per converter cycle
                    else if (!slot_age_reg[i][3] || k < 4'h6)
                        slot_acc_reg[i] <= slot_acc_reg[i] | (slot_raw_reg[i]
                            & (PAIR_MASK << (4'hb - {k[2:0], 1'b0})));
                end
            end
            // a new slot may open on every converter cycle
            if (start_go)
            begin
                slot_v_reg[free_idx] <= 1'b1;
                slot_ch_reg[free_idx] <= grant;
                slot_age_reg[free_idx] <= 4'h0;
                slot_gain_reg[free_idx] <= gain_reg[grant];
                // no gain: converter samples in the start cycle
                slot_raw_reg[free_idx] <= adc_raw;
                slot_acc_reg[free_idx] <= gain_reg[grant] ? 12'h000
                                          : (adc_raw & MSB_MASK);
            end
        end
    end

    // front end strobes follow the slot that is sampling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_enable <= 1'b0;
            sample_strobe <= 1'b0;
            sample_input <= 4'h0;
            gain_sample <= 1'b0;
            cap_discharge <= 1'b0;
        end
        else
        begin
            adc_enable <= enable_reg;
            sample_strobe <= (start_go & !gain_reg[grant])
                             | (conv_tick & hold_reg);
            gain_sample <= start_go & gain_reg[grant];
            // low-impedance mode flushes charge after a gain sample
            cap_discharge <= conv_tick & hold_reg & impmode_reg;
            if (start_go)
                sample_input <= insel_reg[grant]
                    + ((grant == 2'd0) ? {1'b0, scan_ofs_reg} : 4'h0);
        end
    end

    // results, flags and their outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_reg <= 4'h0;
            irq <= 4'h0;
            event_out <= 4'h0;
            dma_req <= 4'h0;
            dma_group_req <= 1'b0;
            for (int c = 0; c < NUM_CH; c++)
                result_reg[c] <= 16'h0000;
        end
        else
        begin
            for (int c = 0; c < NUM_CH; c++)
                if (done[c])
                    // sign extension chosen by the result format
                    result_reg[c] <= format(done_val[c], res_reg, signed_reg);
            // per-channel flag; a new hit outlasts the clearing write
            flag_reg <= (flag_reg
                         & ~((wr_en && !in_ch && paddr == OFS_FLAGS)
                             ? pwdata[3:0] : 4'h0)) | hit;
            irq <= (flag_reg | hit) & irqen_reg;
            event_out <= hit;
            // grouped channels share one dma request
            dma_req <= done & ~grp_mask;
            dma_group_req <= |(done & grp_mask);
        end
    end
endmodule : acs_top
`default_nettype wire

// ### verification/acs_front_model.sv
// event routing and analog front end seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_front_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] fire,
    input wire logic [11:0] level,
    output logic [3:0] event_in,
    output logic [11:0] adc_raw
);
    // one-pclk event, well ahead of the next tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            event_in <= 4'h0;
        else
            event_in <= fire;
    end
    assign adc_raw = level;
endmodule : acs_front_model
`default_nettype wire

// ### verification/acs_top_monitor.sv
// port assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic adc_enable,
    input wire logic sample_strobe,
    input wire logic [3:0] event_out,
    input wire logic [3:0] dma_req,
    input wire logic dma_group_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    chk_sample_space: assert property (
        sample_strobe |=> !sample_strobe [*3]) else $error("samples too close");
    chk_sample_enabled: assert property (
        sample_strobe |-> adc_enable || $past(adc_enable))
        else $error("sample while disabled");
    chk_event_pulse: assert property (
        |event_out |=> event_out == 4'h0) else $error("event not a pulse");
    chk_event_single: assert property ($onehot0(event_out))
        else $error("two completions at once");
    chk_dma_pulse: assert property (|dma_req |=> dma_req == 4'h0)
        else $error("dma request not a pulse");
    chk_group_pulse: assert property (dma_group_req |=> !dma_group_req)
        else $error("group request not a pulse");
endmodule : acs_top_monitor
bind acs_top acs_top_monitor i_acs_top_monitor (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_enable(adc_enable),
    .sample_strobe(sample_strobe), .event_out(event_out),
    .dma_req(dma_req), .dma_group_req(dma_group_req));
`default_nettype wire

// ### verification/test_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_sequencer;
    import acs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, conv_clk, adc_enable, sample_strobe;
    logic gain_sample, cap_discharge, dma_group_req, err;
    logic [3:0] event_in, sample_input, irq, event_out, dma_req;
    logic [3:0] fire = 4'h0;
    logic [11:0] adc_raw;
    logic [11:0] level = 12'h000;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int t_samp = 0;
    logic [3:0] seen_in[$];
    always #2.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (sample_strobe === 1'b1)
        begin
            t_samp <= cyc;
            seen_in.push_back(sample_input);
        end
    end
    acs_top i_acs_top (.*);
    acs_front_model i_acs_front_model (.*);
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : bus
    task automatic wait_ev(input int ch);
        for (int k = 0; k < 600 && event_out[ch] !== 1'b1; k++)
            @(posedge pclk);
        chk("completion", event_out[ch], 1'b1);
    endtask : wait_ev
    task automatic conv(input int ch);
        bus(1'b1, OFS_CTRL, 32'h1 | (32'h4 << ch));
        wait_ev(ch);
    endtask : conv
    task automatic t_regs;
        bus(1'b0, OFS_CMP, 32'h0);
        chk("cmp reset", q, 32'h0);
        bus(1'b1, OFS_CMP, 32'habc);
        bus(1'b0, OFS_CMP, 32'h0);
        chk("cmp", q, 32'habc);
        bus(1'b0, 12'hffc, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_single;
        bus(1'b1, OFS_PRESC, 32'h0);
        bus(1'b1, OFS_CH_BASE, 32'h10);
        bus(1'b1, OFS_CH_BASE + 12'h4, 32'h3);
        level <= 12'h123;
        conv(0);
        chk("ticks 12b", (cyc - t_samp) / 4, 6);
        chk("input", seen_in[$], 3);
        bus(1'b0, OFS_CH_BASE + 12'h8, 32'h0);
        chk("result", q, 32'h123);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("start bits", q, 32'h1);
        chk("irq", irq, 4'h1);
        bus(1'b1, OFS_FLAGS, 32'hf);
        @(posedge pclk);
        chk("irq clear", irq, 4'h0);
        $display("test single done");
    endtask : t_single
    task automatic t_order;
        bus(1'b1, OFS_CH_BASE + 12'h14, 32'h5);
        bus(1'b1, OFS_CH_BASE + 12'h24, 32'h9);
        seen_in.delete();
        bus(1'b1, OFS_CTRL, 32'h19);
        wait_ev(2);
        chk("first", seen_in[0], 5);
        chk("second", seen_in[1], 9);
        $display("test order done");
    endtask : t_order
    task automatic cmp_case(input logic [11:0] lv, input logic [31:0] cfg,
        input logic exp);
        bus(1'b1, OFS_CH_BASE + 12'h30, cfg);
        bus(1'b1, OFS_FLAGS, 32'hf);
        level <= lv;
        fire <= 4'h8;
        @(posedge pclk);
        fire <= 4'h0;
        repeat (40) @(posedge pclk);
        bus(1'b0, OFS_FLAGS, 32'h0);
        chk("cmp flag", q[3], exp);
        chk("cmp irq", irq[3], exp);
    endtask : cmp_case
    task automatic t_cmp;
        bus(1'b1, OFS_CMP, 32'h100);
        cmp_case(12'h080, 32'h14, 1'b0);
        cmp_case(12'h200, 32'h14, 1'b1);
        cmp_case(12'h080, 32'h18, 1'b1);
        $display("test compare done");
    endtask : t_cmp
    task automatic t_format;
        bus(1'b1, OFS_CFG, 32'h10);
        level <= 12'h800;
        conv(0);
        bus(1'b0, OFS_CH_BASE + 12'h8, 32'h0);
        chk("signed", q, 32'hf800);
        bus(1'b1, OFS_CFG, 32'h4);
        conv(0);
        chk("ticks 8b", (cyc - t_samp) / 4, 4);
        bus(1'b1, OFS_CH_BASE, 32'h11);
        conv(0);
        chk("ticks gain", (cyc - t_samp) / 4, 4);
        $display("test format done");
    endtask : t_format
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    initial
    begin
        #100000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_single();
        t_order();
        t_cmp();
        t_format();
        complete_run();
    end
endmodule : test_adc_conversion_sequencer
`default_nettype wire
